//--- hdl/spme_pkg.sv
// package: constants and tx helper for serial programming mode entry
// ============================================================================
package spme_pkg;

  // ==========================================================================
  // clock and documented times
  localparam longint unsigned CLK_HZ        = 100_000_000;
  localparam longint unsigned TOOL_SETUP_US = 10;
  localparam longint unsigned TOOL_HOLD_MS  = 1;
  localparam longint unsigned INIT_LIMIT_MS = 100;
  localparam longint unsigned BAUD_MIN_BPS  = 115_200;
  localparam longint unsigned BAUD_MAX_BPS  = 1_000_000;

  // ==========================================================================
  // derived cycle counts: least times round up, longest round down
  localparam int unsigned SETUP_CYC   = int'((TOOL_SETUP_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int unsigned HOLD_CYC    = int'((TOOL_HOLD_MS * CLK_HZ + 999) / 1_000);
  localparam int unsigned INIT_CYC    = int'((INIT_LIMIT_MS * CLK_HZ) / 1_000);
  localparam int unsigned BIT_CYC_MIN = int'((CLK_HZ + BAUD_MAX_BPS - 1) / BAUD_MAX_BPS);
  localparam int unsigned BIT_CYC_MAX = int'(CLK_HZ / BAUD_MIN_BPS);

  // ==========================================================================
  // widths
  localparam int TMR_W = 24;
  localparam int DIV_W = 10;
  localparam int ERR_W = 3;

  // ==========================================================================
  // characters of the initial exchange
  localparam logic [7:0] SYNC_CHAR = 8'hFF;
  localparam logic [7:0] ENTRY_CMD = 8'h3A;
  localparam logic [7:0] ENTRY_ACK = 8'h06;

  // frame slot index: one idle gap bit, start, 8 data lsb first, stop
  localparam logic [3:0] BIT_GAP   = 4'h0;
  localparam logic [3:0] BIT_START = 4'h1;
  localparam logic [3:0] BIT_STOP  = 4'hA;

  // ==========================================================================
  // device failure reasons
  localparam logic [ERR_W-1:0] ERR_NONE    = 3'h0;
  localparam logic [ERR_W-1:0] ERR_RST_SRC = 3'h1;
  localparam logic [ERR_W-1:0] ERR_BAUD    = 3'h2;
  localparam logic [ERR_W-1:0] ERR_FRAME   = 3'h3;
  localparam logic [ERR_W-1:0] ERR_TIMEOUT = 3'h4;

  // line level for a frame slot
  function automatic logic tx_level(input logic [3:0] idx, input logic lsb);
    logic lvl;
    lvl = 1'b1;
    if (idx == BIT_START) begin
      lvl = 1'b0;
    end else if (idx != BIT_GAP && idx != BIT_STOP) begin
      lvl = lsb;
    end
    return lvl;
  endfunction : tx_level

endpackage : spme_pkg

//--- hdl/spme_if.sv
// interface: external reset and open-drain tool pin between the two ends
`timescale 1ns/1ps
`default_nettype none
interface spme_if;
  logic      rst_ext_n;
  logic      prg_tool_out;
  logic      prg_tool_oe;
  logic      dev_tool_out;
  logic      dev_tool_oe;
  wire logic tool_level;

  // pulled up; either end may pull it low
  assign tool_level = ~((prg_tool_oe & ~prg_tool_out) | (dev_tool_oe & ~dev_tool_out));

  modport dev (input rst_ext_n, input tool_level, output dev_tool_out, output dev_tool_oe);
  modport prg (output rst_ext_n, output prg_tool_out, output prg_tool_oe, input tool_level);
endinterface : spme_if
`default_nettype wire

//--- hdl/spme_dev.sv
// device end: mode entry on reset release, baud lock and entry acknowledge
`timescale 1ns/1ps
`default_nettype none
module spme_dev #(
  parameter int unsigned HOLD_CYC = spme_pkg::HOLD_CYC,
  parameter int unsigned INIT_CYC = spme_pkg::INIT_CYC
) (
  // clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        ARST_N_I,
  // link to the programmer
  spme_if.dev                              LINK,
  // internal reset sources, high while active
  input  wire logic                        POR_RST_I,
  input  wire logic                        LVD_RST_I,
  // entry outcome
  output logic                             PROG_MODE_O,
  output logic                             NORMAL_BOOT_O,
  output logic                             ENTRY_FAIL_O,
  output logic [spme_pkg::ERR_W-1:0]       ERR_CODE_O,
  output logic [spme_pkg::DIV_W-1:0]       BAUD_DIV_O
);

  localparam int TW = spme_pkg::TMR_W;
  localparam int DW = spme_pkg::DIV_W;
  localparam int EW = spme_pkg::ERR_W;

  localparam logic [TW-1:0] hold_lim = TW'(HOLD_CYC);
  localparam logic [TW-1:0] init_lim = TW'(INIT_CYC);
  localparam logic [DW-1:0] bit_min  = DW'(spme_pkg::BIT_CYC_MIN);
  localparam logic [DW-1:0] bit_max  = DW'(spme_pkg::BIT_CYC_MAX);

  typedef enum {
    S_RESET,
    S_HOLD,
    S_WAIT_HIGH,
    S_MEASURE,
    S_RX,
    S_TX,
    S_PROG,
    S_BOOT,
    S_FAIL
  } spme_dev_state_type;

  // ==========================================================================
  // pin synchronisers
  logic [2:0] rst_sync_ff;
  logic [2:0] tool_sync_ff;
  logic       rst_lvl_ff;
  logic       tool_lvl_ff;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync_ff  <= 3'h0;
      tool_sync_ff <= 3'h7;
      rst_lvl_ff   <= 1'b0;
      tool_lvl_ff  <= 1'b1;
    end else begin
      rst_sync_ff  <= {rst_sync_ff[1:0], LINK.rst_ext_n};
      tool_sync_ff <= {tool_sync_ff[1:0], LINK.tool_level};
      // a change counts only once the second and third stages agree
      if (rst_sync_ff[1] == rst_sync_ff[2]) begin
        rst_lvl_ff <= rst_sync_ff[2];
      end
      if (tool_sync_ff[1] == tool_sync_ff[2]) begin
        tool_lvl_ff <= tool_sync_ff[2];
      end
    end
  end

  // ==========================================================================
  // state
  spme_dev_state_type state_ff;
  spme_dev_state_type nxt_state;
  logic [DW-1:0]      cnt_ff;
  logic [DW-1:0]      nxt_cnt;
  logic [DW-1:0]      baud_ff;
  logic [DW-1:0]      nxt_baud;
  logic [TW-1:0]      tmr_ff;
  logic [TW-1:0]      nxt_tmr;
  logic [3:0]         bit_ff;
  logic [3:0]         nxt_bit;
  logic [7:0]         sh_ff;
  logic [7:0]         nxt_sh;
  logic               act_ff;
  logic               nxt_act;
  logic [EW-1:0]      err_ff;
  logic [EW-1:0]      nxt_err;
  logic               prog_ff;
  logic               boot_ff;
  logic               fail_ff;

  // ==========================================================================
  // decodes
  wire logic in_window = (state_ff == S_HOLD) || (state_ff == S_WAIT_HIGH) ||
                         (state_ff == S_MEASURE) || (state_ff == S_RX) ||
                         (state_ff == S_TX);
  wire logic timeout   = in_window && (tmr_ff == init_lim - 1'b1);
  wire logic cnt_zero  = (cnt_ff == '0);
  wire logic baud_ok   = (cnt_ff >= bit_min) && (cnt_ff <= bit_max);
  wire logic tx_lvl    = spme_pkg::tx_level(bit_ff, sh_ff[0]);
  wire logic data_slot = (bit_ff > spme_pkg::BIT_START) && (bit_ff != spme_pkg::BIT_STOP);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_baud  = baud_ff;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    nxt_act   = act_ff;
    nxt_err   = err_ff;
    nxt_tmr   = in_window ? tmr_ff + 1'b1 : '0;
    case (state_ff)
      S_RESET: begin
        if (rst_lvl_ff) begin
          if (POR_RST_I || LVD_RST_I) begin
            nxt_state = S_FAIL;
            nxt_err   = spme_pkg::ERR_RST_SRC;
          end else if (!tool_lvl_ff) begin
            nxt_state = S_HOLD;
          end else begin
            nxt_state = S_BOOT;
          end
        end
      end
      S_HOLD: begin
        // the line is not watched until the hold time is over
        if (tmr_ff >= hold_lim) begin
          nxt_state = S_WAIT_HIGH;
        end
      end
      S_WAIT_HIGH: begin
        if (tool_lvl_ff) begin
          nxt_state = S_MEASURE;
          nxt_act   = 1'b0;
          nxt_cnt   = '0;
        end
      end
      S_MEASURE: begin
        // sync character has lsb set, so the first low pulse is one bit
        if (!act_ff) begin
          if (!tool_lvl_ff) begin
            nxt_act = 1'b1;
            nxt_cnt = DW'(1);
          end
        end else if (!tool_lvl_ff) begin
          if (cnt_ff != '1) begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end else if (baud_ok) begin
          nxt_baud  = cnt_ff;
          nxt_act   = 1'b0;
          nxt_state = S_RX;
        end else begin
          nxt_state = S_FAIL;
          nxt_err   = spme_pkg::ERR_BAUD;
        end
      end
      S_RX: begin
        // remaining sync data bits are high, so the next fall is the command
        if (!act_ff) begin
          if (!tool_lvl_ff) begin
            nxt_act = 1'b1;
            nxt_cnt = baud_ff >> 1;
            nxt_bit = spme_pkg::BIT_START;
          end
        end else if (!cnt_zero) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_cnt = baud_ff - 1'b1;
          if (bit_ff == spme_pkg::BIT_START) begin
            if (tool_lvl_ff) begin
              nxt_act = 1'b0;
            end else begin
              nxt_bit = bit_ff + 1'b1;
            end
          end else if (bit_ff != spme_pkg::BIT_STOP) begin
            nxt_sh  = {tool_lvl_ff, sh_ff[7:1]};
            nxt_bit = bit_ff + 1'b1;
          end else if (tool_lvl_ff && sh_ff == spme_pkg::ENTRY_CMD) begin
            nxt_state = S_TX;
            nxt_bit   = spme_pkg::BIT_GAP;
            nxt_sh    = spme_pkg::ENTRY_ACK;
          end else begin
            nxt_state = S_FAIL;
            nxt_err   = spme_pkg::ERR_FRAME;
          end
        end
      end
      S_TX: begin
        // leading gap slot lets the programmer finish its own stop bit
        if (!cnt_zero) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_cnt = baud_ff - 1'b1;
          if (bit_ff == spme_pkg::BIT_STOP) begin
            nxt_state = S_PROG;
          end else begin
            nxt_bit = bit_ff + 1'b1;
            if (data_slot) begin
              nxt_sh = sh_ff >> 1;
            end
          end
        end
      end
      S_PROG, S_BOOT, S_FAIL: begin
        nxt_state = state_ff;
      end
      default: begin
        nxt_state = S_RESET;
      end
    endcase
    if (timeout) begin
      nxt_state = S_FAIL;
      nxt_err   = spme_pkg::ERR_TIMEOUT;
    end
    if (!rst_lvl_ff) begin
      nxt_state = S_RESET;
      nxt_act   = 1'b0;
      nxt_err   = spme_pkg::ERR_NONE;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff <= S_RESET;
      cnt_ff   <= '0;
      baud_ff  <= '0;
      tmr_ff   <= '0;
      bit_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      act_ff   <= 1'b0;
      err_ff   <= spme_pkg::ERR_NONE;
      prog_ff  <= 1'b0;
      boot_ff  <= 1'b0;
      fail_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      baud_ff  <= nxt_baud;
      tmr_ff   <= nxt_tmr;
      bit_ff   <= nxt_bit;
      sh_ff    <= nxt_sh;
      act_ff   <= nxt_act;
      err_ff   <= nxt_err;
      prog_ff  <= (nxt_state == S_PROG);
      boot_ff  <= (nxt_state == S_BOOT);
      fail_ff  <= (nxt_state == S_FAIL);
    end
  end

  // ==========================================================================
  // outputs
  assign PROG_MODE_O       = prog_ff;
  assign NORMAL_BOOT_O     = boot_ff;
  assign ENTRY_FAIL_O      = fail_ff;
  assign ERR_CODE_O        = err_ff;
  assign BAUD_DIV_O        = baud_ff;
  assign LINK.dev_tool_out = 1'b0;
  assign LINK.dev_tool_oe  = (state_ff == S_TX) && !tx_lvl;

endmodule : spme_dev
`default_nettype wire

//--- hdl/spme_prg.sv
// programmer end: reset and tool sequencing, sync and entry command, ack check
`timescale 1ns/1ps
`default_nettype none
module spme_prg #(
  parameter int unsigned HOLD_CYC = spme_pkg::HOLD_CYC,
  parameter int unsigned INIT_CYC = spme_pkg::INIT_CYC
) (
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  ARST_N_I,
  // link to the device
  spme_if.prg                        LINK,
  // user request
  input  wire logic                  START_I,
  input  wire logic [spme_pkg::DIV_W-1:0] BAUD_DIV_I,
  // user status
  output logic                       BUSY_O,
  output logic                       DONE_O,
  output logic                       FAIL_O
);

  localparam int TW = spme_pkg::TMR_W;
  localparam int DW = spme_pkg::DIV_W;

  localparam logic [TW-1:0] setup_lim = TW'(spme_pkg::SETUP_CYC);
  localparam logic [TW-1:0] hold_lim  = TW'(HOLD_CYC);
  localparam logic [TW-1:0] init_lim  = TW'(INIT_CYC);
  localparam logic [DW-1:0] bit_min   = DW'(spme_pkg::BIT_CYC_MIN);
  localparam logic [DW-1:0] bit_max   = DW'(spme_pkg::BIT_CYC_MAX);

  typedef enum {P_IDLE, P_SETUP, P_HOLD, P_TX, P_RX} spme_prg_state_type;

  // ==========================================================================
  // tool pin synchroniser
  logic [2:0] tool_sync_ff;
  logic       tool_lvl_ff;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tool_sync_ff <= 3'h7;
      tool_lvl_ff  <= 1'b1;
    end else begin
      tool_sync_ff <= {tool_sync_ff[1:0], LINK.tool_level};
      if (tool_sync_ff[1] == tool_sync_ff[2]) begin
        tool_lvl_ff <= tool_sync_ff[2];
      end
    end
  end

  // ==========================================================================
  // state
  spme_prg_state_type state_ff;
  spme_prg_state_type nxt_state;
  logic [DW-1:0]      cnt_ff;
  logic [DW-1:0]      nxt_cnt;
  logic [DW-1:0]      div_ff;
  logic [DW-1:0]      nxt_div;
  logic [TW-1:0]      tmr_ff;
  logic [TW-1:0]      nxt_tmr;
  logic [3:0]         bit_ff;
  logic [3:0]         nxt_bit;
  logic [7:0]         sh_ff;
  logic [7:0]         nxt_sh;
  logic               act_ff;
  logic               nxt_act;
  logic               second_ff;
  logic               nxt_second;
  logic               done_ff;
  logic               nxt_done;
  logic               fail_ff;
  logic               nxt_fail;

  wire logic div_ok    = (BAUD_DIV_I >= bit_min) && (BAUD_DIV_I <= bit_max);
  wire logic cnt_zero  = (cnt_ff == '0);
  wire logic tx_lvl    = spme_pkg::tx_level(bit_ff, sh_ff[0]);
  wire logic data_slot = (bit_ff > spme_pkg::BIT_START) && (bit_ff != spme_pkg::BIT_STOP);
  wire logic timeout   = (state_ff != P_IDLE) && (state_ff != P_SETUP) &&
                         (tmr_ff == init_lim - 1'b1);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_div    = div_ff;
    nxt_tmr    = tmr_ff + 1'b1;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_act    = act_ff;
    nxt_second = second_ff;
    nxt_done   = 1'b0;
    nxt_fail   = 1'b0;
    case (state_ff)
      P_IDLE: begin
        nxt_tmr = '0;
        if (START_I) begin
          if (div_ok) begin
            nxt_state = P_SETUP;
            nxt_div   = BAUD_DIV_I;
          end else begin
            nxt_fail = 1'b1;
          end
        end
      end
      P_SETUP: begin
        if (tmr_ff == setup_lim - 1'b1) begin
          nxt_state = P_HOLD;
          nxt_tmr   = '0;
        end
      end
      P_HOLD: begin
        if (tmr_ff >= hold_lim) begin
          nxt_state  = P_TX;
          nxt_bit    = spme_pkg::BIT_GAP;
          nxt_cnt    = div_ff - 1'b1;
          nxt_sh     = spme_pkg::SYNC_CHAR;
          nxt_second = 1'b0;
        end
      end
      P_TX: begin
        if (!cnt_zero) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_cnt = div_ff - 1'b1;
          if (bit_ff != spme_pkg::BIT_STOP) begin
            nxt_bit = bit_ff + 1'b1;
            if (data_slot) begin
              nxt_sh = sh_ff >> 1;
            end
          end else if (!second_ff) begin
            nxt_bit    = spme_pkg::BIT_GAP;
            nxt_sh     = spme_pkg::ENTRY_CMD;
            nxt_second = 1'b1;
          end else begin
            nxt_state = P_RX;
            nxt_act   = 1'b0;
          end
        end
      end
      P_RX: begin
        if (!act_ff) begin
          if (!tool_lvl_ff) begin
            nxt_act = 1'b1;
            nxt_cnt = div_ff >> 1;
            nxt_bit = spme_pkg::BIT_START;
          end
        end else if (!cnt_zero) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_cnt = div_ff - 1'b1;
          if (bit_ff == spme_pkg::BIT_START) begin
            if (tool_lvl_ff) begin
              nxt_act = 1'b0;
            end else begin
              nxt_bit = bit_ff + 1'b1;
            end
          end else if (bit_ff != spme_pkg::BIT_STOP) begin
            nxt_sh  = {tool_lvl_ff, sh_ff[7:1]};
            nxt_bit = bit_ff + 1'b1;
          end else begin
            nxt_state = P_IDLE;
            nxt_done  = tool_lvl_ff && (sh_ff == spme_pkg::ENTRY_ACK);
            nxt_fail  = !(tool_lvl_ff && (sh_ff == spme_pkg::ENTRY_ACK));
          end
        end
      end
      default: begin
        nxt_state = P_IDLE;
      end
    endcase
    if (timeout) begin
      nxt_state = P_IDLE;
      nxt_fail  = 1'b1;
      nxt_done  = 1'b0;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff  <= P_IDLE;
      cnt_ff    <= '0;
      div_ff    <= '0;
      tmr_ff    <= '0;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      act_ff    <= 1'b0;
      second_ff <= 1'b0;
      done_ff   <= 1'b0;
      fail_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      div_ff    <= nxt_div;
      tmr_ff    <= nxt_tmr;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      act_ff    <= nxt_act;
      second_ff <= nxt_second;
      done_ff   <= nxt_done;
      fail_ff   <= nxt_fail;
    end
  end

  // ==========================================================================
  // outputs; tool is pulled low through setup and hold, then only for low bits
  assign BUSY_O            = (state_ff != P_IDLE);
  assign DONE_O            = done_ff;
  assign FAIL_O            = fail_ff;
  assign LINK.rst_ext_n    = (state_ff != P_SETUP);
  assign LINK.prg_tool_out = 1'b0;
  assign LINK.prg_tool_oe  = (state_ff == P_SETUP) || (state_ff == P_HOLD) ||
                             ((state_ff == P_TX) && !tx_lvl);

endmodule : spme_prg
`default_nettype wire

//--- sim/spme_monitor.sv
// checker: link timing and entry outcome of the programmer and device pair
`timescale 1ns/1ps
`default_nettype none
module spme_monitor #(
  parameter int HOLD_CYC = 200,
  parameter int INIT_CYC = 20000
) (
  // clock and reset
  input wire logic       CLK_I,
  input wire logic       ARST_N_I,
  // link
  input wire logic       rst_ext_n,
  input wire logic       prg_tool_oe,
  input wire logic       dev_tool_oe,
  input wire logic       tool_level,
  // programmer user side
  input wire logic       START_I,
  input wire logic [9:0] BAUD_DIV_I,
  input wire logic       BUSY_O,
  input wire logic       DONE_O,
  input wire logic       FAIL_O,
  // device outcome
  input wire logic       PROG_MODE_O,
  input wire logic       NORMAL_BOOT_O,
  input wire logic       ENTRY_FAIL_O
);
  localparam int HOLD_HI = HOLD_CYC + 4;
  localparam int LIM     = INIT_CYC + 8;
  logic [23:0] low_cnt_ff;
  logic [23:0] hold_cnt_ff;
  logic [23:0] since_ff;
  logic        armed_ff;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  // ==========================================================================
  // helper counters; they saturate so a long idle never wraps
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      low_cnt_ff  <= 24'h0;
      hold_cnt_ff <= 24'h0;
      since_ff    <= 24'h0;
      armed_ff    <= 1'b0;
    end else begin
      low_cnt_ff  <= rst_ext_n ? 24'h0 : low_cnt_ff + {23'h0, ~tool_level & ~&low_cnt_ff};
      hold_cnt_ff <= !rst_ext_n ? 24'h0 : hold_cnt_ff + {23'h0, prg_tool_oe & ~&hold_cnt_ff};
      since_ff    <= !rst_ext_n ? 24'h0 : since_ff + {23'h0, ~&since_ff};
      armed_ff    <= armed_ff | ~rst_ext_n;
    end
  end

  // ==========================================================================
  // assertions
  a_setup_before_release: assert property (
    $rose(rst_ext_n) |-> low_cnt_ff >= 24'(spme_pkg::SETUP_CYC))
    else $error("external reset released before the tool setup time");
  a_tool_low_release: assert property ($rose(rst_ext_n) |-> !tool_level)
    else $error("tool pin not low at reset release");
  a_hold_after_release: assert property (
    $fell(prg_tool_oe) && rst_ext_n |-> hold_cnt_ff >= 24'(HOLD_CYC))
    else $error("tool pin released before the hold time");
  a_tool_released_high: assert property (
    $rose(rst_ext_n) |-> ##[HOLD_CYC:HOLD_HI] !prg_tool_oe)
    else $error("tool pin not released after the hold time");
  a_done_in_limit: assert property (DONE_O |-> armed_ff && since_ff < 24'(INIT_CYC))
    else $error("exchange finished after the limit");
  a_outcome_by_limit: assert property (
    armed_ff && since_ff == 24'(LIM) |-> PROG_MODE_O || ENTRY_FAIL_O || NORMAL_BOOT_O)
    else $error("device still undecided after the limit");
  a_prog_after_done: assert property ($rose(DONE_O) |-> ##[1:1000] PROG_MODE_O)
    else $error("programming mode not entered after the acknowledge");
  a_device_quiet_hold: assert property ($rose(rst_ext_n) |-> !dev_tool_oe [*8])
    else $error("device drives the tool pin during the hold");
  a_no_boot_on_low: assert property (
    $rose(rst_ext_n) && !tool_level |-> ##1 !NORMAL_BOOT_O [*8])
    else $error("normal boot chosen with tool low");
  a_rate_refused: assert property (
    START_I && !BUSY_O && (BAUD_DIV_I < 10'h064 || BAUD_DIV_I > 10'h364)
    |=> FAIL_O && rst_ext_n)
    else $error("out of range bit period not refused");

  c_prog_entered: cover property ($rose(PROG_MODE_O));
  c_rate_fail: cover property (FAIL_O);
  c_hold_end: cover property ($fell(prg_tool_oe) && rst_ext_n);
endmodule : spme_monitor
`default_nettype wire

//--- sim/spme_tb.sv
// testbench: programmer and device joined, plus a second device driven by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int HOLD = 200;
  localparam int INIT = 29000;
  logic       clk, arst_n, start, por_b, lvd_b;
  logic       busy, done, fail, prog, boot, efail, prog_b, boot_b, efail_b;
  logic [9:0] div, bdiv, bdiv_b;
  logic [2:0] err, err_b;
  int         fails, n_compared;
  spme_if link_a ();
  spme_if link_b ();

  spme_prg #(.HOLD_CYC(HOLD), .INIT_CYC(INIT)) i_spme_prg (.CLK_I(clk), .ARST_N_I(arst_n),
    .LINK(link_a), .START_I(start), .BAUD_DIV_I(div), .BUSY_O(busy), .DONE_O(done),
    .FAIL_O(fail));
  spme_dev #(.HOLD_CYC(HOLD), .INIT_CYC(INIT)) i_spme_dev (.CLK_I(clk), .ARST_N_I(arst_n),
    .LINK(link_a), .POR_RST_I(1'b0), .LVD_RST_I(1'b0), .PROG_MODE_O(prog),
    .NORMAL_BOOT_O(boot), .ENTRY_FAIL_O(efail), .ERR_CODE_O(err), .BAUD_DIV_O(bdiv));
  spme_dev #(.HOLD_CYC(HOLD), .INIT_CYC(INIT)) i_spme_dev_b (.CLK_I(clk), .ARST_N_I(arst_n),
    .LINK(link_b), .POR_RST_I(por_b), .LVD_RST_I(lvd_b), .PROG_MODE_O(prog_b),
    .NORMAL_BOOT_O(boot_b), .ENTRY_FAIL_O(efail_b), .ERR_CODE_O(err_b), .BAUD_DIV_O(bdiv_b));
  spme_monitor #(.HOLD_CYC(HOLD), .INIT_CYC(INIT)) i_spme_monitor (.CLK_I(clk),
    .ARST_N_I(arst_n), .rst_ext_n(link_a.rst_ext_n), .prg_tool_oe(link_a.prg_tool_oe),
    .dev_tool_oe(link_a.dev_tool_oe), .tool_level(link_a.tool_level), .START_I(start),
    .BAUD_DIV_I(div), .BUSY_O(busy), .DONE_O(done), .FAIL_O(fail), .PROG_MODE_O(prog),
    .NORMAL_BOOT_O(boot), .ENTRY_FAIL_O(efail));

  // ==========================================================================
  // tasks
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask : chk

  // sample a little after the edge so the design's updates have landed
  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : stp

  task automatic rx_byte(input int d, output logic [7:0] b);
    int n;
    n = 0;
    while (link_a.tool_level !== 1'b0 && n < 4 * d) begin
      stp(1);
      n++;
    end
    stp(d / 2);
    for (int i = 0; i < 8; i++) begin
      stp(d);
      b[i] = link_a.tool_level;
    end
    stp(d);
    chk({15'h0, link_a.tool_level}, 16'h1, "stop bit");
  endtask : rx_byte

  task automatic run_a(input logic [9:0] d);
    logic [7:0] b;
    int         n;
    @(posedge clk) begin start <= 1'b1; div <= d; end
    @(posedge clk) start <= 1'b0;
    stp(1);
    n = 0;
    while (link_a.rst_ext_n === 1'b0 && n < 5000) begin stp(1); n++; end
    chk({15'h0, n + 1 >= spme_pkg::SETUP_CYC}, 16'h1, "reset low time");
    n = 0;
    while (link_a.prg_tool_oe === 1'b1 && n < 4 * HOLD) begin stp(1); n++; end
    chk({15'h0, n >= HOLD}, 16'h1, "tool hold time");
    rx_byte(d, b);
    chk({8'h0, b}, {8'h0, spme_pkg::SYNC_CHAR}, "sync char");
    rx_byte(d, b);
    chk({8'h0, b}, {8'h0, spme_pkg::ENTRY_CMD}, "entry command");
    rx_byte(d, b);
    chk({8'h0, b}, {8'h0, spme_pkg::ENTRY_ACK}, "acknowledge");
    n = 0;
    while (prog !== 1'b1 && n < 4 * d) begin stp(1); n++; end
    chk({11'h0, prog, busy, err}, 16'h10, "programming mode");
    chk({15'h0, bdiv + 10'h1 >= d && bdiv <= d + 10'h1}, 16'h1, "locked rate");
  endtask : run_a

  task automatic bad_a(input logic [9:0] d);
    @(posedge clk) begin start <= 1'b1; div <= d; end
    @(posedge clk) start <= 1'b0;
    #1;
    chk({14'h0, fail, link_a.rst_ext_n}, 16'h3, "rate refused");
    stp(2);
  endtask : bad_a

  // gap, start, eight data bits lsb first, stop
  task automatic send_b(input int d, input logic [7:0] v);
    logic [10:0] fr;
    fr = {1'b1, v, 1'b0, 1'b1};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) link_b.prg_tool_oe <= ~fr[i];
      stp(d - 1);
    end
  endtask : send_b

  task automatic run_b(input logic p, input logic l, input logic tl, input int d,
                       input logic [7:0] cmd, input logic snd, input logic [2:0] code);
    int n;
    @(posedge clk) begin
      por_b <= p;
      lvd_b <= l;
      link_b.rst_ext_n <= 1'b0;
      link_b.prg_tool_oe <= tl;
    end
    stp(spme_pkg::SETUP_CYC);
    @(posedge clk) link_b.rst_ext_n <= 1'b1;
    stp(HOLD + 1);
    @(posedge clk) link_b.prg_tool_oe <= 1'b0;
    if (snd) begin
      send_b(d, spme_pkg::SYNC_CHAR);
      send_b(d, cmd);
    end
    n = 0;
    while ((prog_b | boot_b | efail_b) !== 1'b1 && n < INIT + 200) begin stp(1); n++; end
    chk({13'h0, err_b}, {13'h0, code}, "fail reason");
    chk({13'h0, prog_b, boot_b, efail_b}, {13'h0, code == 3'h0 && tl, code == 3'h0 && !tl,
        code != 3'h0}, "entry outcome");
    @(posedge clk) begin por_b <= 1'b0; lvd_b <= 1'b0; end
  endtask : run_b

  // ==========================================================================
  // clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #1_500_000;
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    arst_n = 1'b0;
    start = 1'b0;
    div = 10'h064;
    por_b = 1'b0;
    lvd_b = 1'b0;
    link_b.rst_ext_n = 1'b1;
    link_b.prg_tool_out = 1'b0;
    link_b.prg_tool_oe = 1'b0;
    repeat (16) @(posedge clk);
    @(posedge clk) arst_n <= 1'b1;
    stp(2);
    run_a(10'h064);
    run_a(10'h364);
    bad_a(10'h063);
    bad_a(10'h365);
    run_b(1'b1, 1'b0, 1'b1, 100, spme_pkg::ENTRY_CMD, 1'b1, spme_pkg::ERR_RST_SRC);
    run_b(1'b0, 1'b1, 1'b1, 100, spme_pkg::ENTRY_CMD, 1'b1, spme_pkg::ERR_RST_SRC);
    run_b(1'b0, 1'b0, 1'b0, 100, spme_pkg::ENTRY_CMD, 1'b0, spme_pkg::ERR_NONE);
    run_b(1'b0, 1'b0, 1'b1, 99, spme_pkg::ENTRY_CMD, 1'b1, spme_pkg::ERR_BAUD);
    run_b(1'b0, 1'b0, 1'b1, 869, spme_pkg::ENTRY_CMD, 1'b1, spme_pkg::ERR_BAUD);
    run_b(1'b0, 1'b0, 1'b1, 100, 8'h55, 1'b1, spme_pkg::ERR_FRAME);
    run_b(1'b0, 1'b0, 1'b1, 100, spme_pkg::ENTRY_CMD, 1'b0, spme_pkg::ERR_TIMEOUT);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
